// file: common/nsr_defines.vh
// Constants for the negate, stack and relative call execute block
`ifndef NSR_DEFINES_VH
`define NSR_DEFINES_VH
// ************************************************************
// Register offsets (byte addresses)
// ************************************************************
`define NSR_OFF_BANK     6'h00
`define NSR_OFF_FLAGS    6'h04
`define NSR_OFF_TOP      6'h08
`define NSR_OFF_LEVEL    6'h0C
`define NSR_OFF_EXEC     6'h10
// ************************************************************
// Flag positions and reset values
// ************************************************************
`define NSR_FLAG_C       0
`define NSR_FLAG_DC      1
`define NSR_FLAG_Z       2
`define NSR_FLAG_OV      3
`define NSR_FLAG_N       4
`define NSR_RST_FLAGS    5'h00
`define NSR_RST_BANK     4'h0
`define NSR_LVL_FULL     8
`define NSR_LVL_EMPTY    9
// ************************************************************
// Opcode patterns
// ************************************************************
`define NSR_NEG_MASK     16'hFE00
`define NSR_NEG_CODE     16'h6C00
`define NSR_POP_CODE     16'h0006
`define NSR_PUSH_CODE    16'h0005
`define NSR_CALL_MASK    16'hF800
`define NSR_CALL_CODE    16'hD800
`define NSR_IDLE_CODE    16'h0000
`define NSR_IDLE_TOP     4'hF
`define NSR_ACC_SPLIT    8'h80
`define NSR_ACC_HIBANK   4'hF
`define NSR_PC_STEP      21'h00_0002
// ************************************************************
// Timing: one instruction cycle is four phases of aclk
// ************************************************************
`define NSR_PHASES       4
`define NSR_RESP_OKAY    2'b00
`define NSR_RESP_SLVERR  2'b10
`endif

// file: hdl/nsr_exec.v
// Decode and execute of negate, idle, pop, push and relative call
`include "nsr_defines.vh"
module nsr_exec #(
	parameter PCW = 21,
	parameter SD  = 31,
	parameter SPW = 5
) (
	// Clock and reset
	input  wire           aclk,
	input  wire           aresetn,
	// AXI4-Lite write address
	input  wire [5:0]     s_axi_awaddr,
	input  wire           s_axi_awvalid,
	output wire           s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0]    s_axi_wdata,
	input  wire [3:0]     s_axi_wstrb,
	input  wire           s_axi_wvalid,
	output wire           s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]     s_axi_bresp,
	output reg            s_axi_bvalid,
	input  wire           s_axi_bready,
	// AXI4-Lite read address
	input  wire [5:0]     s_axi_araddr,
	input  wire           s_axi_arvalid,
	output wire           s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0]    s_axi_rdata,
	output reg  [1:0]     s_axi_rresp,
	output reg            s_axi_rvalid,
	input  wire           s_axi_rready,
	// Fetch unit
	input  wire [15:0]    instr_word,
	input  wire           instr_valid,
	input  wire [PCW-1:0] pc_cur,
	output reg            pc_load,
	output reg  [PCW-1:0] pc_target,
	output reg            refetch,
	output reg  [3:0]     phase,
	// Banked data memory
	output reg  [11:0]    mem_addr,
	output reg            mem_rd,
	input  wire [7:0]     mem_rdata,
	output reg  [7:0]     mem_wdata,
	output reg            mem_we
);
	// ************************************************************
	// Phases and decoded operations
	// ************************************************************
	localparam [3:0] Q1 = 4'b0001;
	localparam [3:0] Q2 = 4'b0010;
	localparam [3:0] Q3 = 4'b0100;
	localparam [3:0] Q4 = 4'b1000;
	localparam [5:0] OP_NONE = 6'b000001;
	localparam [5:0] OP_IDLE = 6'b000010;
	localparam [5:0] OP_NEG  = 6'b000100;
	localparam [5:0] OP_POP  = 6'b001000;
	localparam [5:0] OP_PUSH = 6'b010000;
	localparam [5:0] OP_CALL = 6'b100000;

	// Classify one instruction word
	function [5:0] nsr_decode;
		input [15:0] w;
		begin
			if ((w & `NSR_NEG_MASK) == `NSR_NEG_CODE)
				nsr_decode = OP_NEG;
			else if (w == `NSR_POP_CODE)
				nsr_decode = OP_POP;
			else if (w == `NSR_PUSH_CODE)
				nsr_decode = OP_PUSH;
			else if ((w & `NSR_CALL_MASK) == `NSR_CALL_CODE)
				nsr_decode = OP_CALL;
			else if (w == `NSR_IDLE_CODE || w[15:12] == `NSR_IDLE_TOP)
				nsr_decode = OP_IDLE;
			else
				nsr_decode = OP_NONE;
		end
	endfunction

	// Address of the operand: quick access bank or selected bank
	function [11:0] nsr_faddr;
		input       a;
		input [7:0] f;
		input [3:0] bank;
		begin
			if (a)
				nsr_faddr = {bank, f};
			else if (f < `NSR_ACC_SPLIT)
				nsr_faddr = {4'h0, f};
			else
				nsr_faddr = {`NSR_ACC_HIBANK, f};
		end
	endfunction

	// ************************************************************
	// State
	// ************************************************************
	reg  [5:0]     op;
	reg  [15:0]    iw;
	reg  [PCW-1:0] ret_addr;
	reg            squash;
	reg  [7:0]     operand;
	reg  [7:0]     result;
	reg  [4:0]     flags;
	reg  [3:0]     bank;
	reg  [5:0]     last_op;
	reg            stk_push;
	reg            stk_pop;
	wire [PCW-1:0] stk_top;
	wire [SPW-1:0] stk_level;
	wire           stk_full;
	wire           stk_empty;
	wire [PCW-1:0] rel_off;
	wire [7:0]     neg_val;

	// Offset n doubled and sign-extended; negate of the byte on the read port
	assign rel_off = {{(PCW-12){iw[10]}}, iw[10:0], 1'b0};
	assign neg_val = ~mem_rdata + 8'h01;

	// ************************************************************
	// Return stack
	// ************************************************************
	nsr_stack #(
		.W  (PCW),
		.D  (SD),
		.PW (SPW)
	) u_stack (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.push      (stk_push),
		.pop       (stk_pop),
		.push_data (ret_addr),
		.top       (stk_top),
		.level     (stk_level),
		.full      (stk_full),
		.empty     (stk_empty)
	);

	// ************************************************************
	// Phase sequencer and execution
	// ************************************************************
	// One-hot phase ring; an instruction is taken in Q1
	always @(posedge aclk) begin
		if (!aresetn) begin
			phase     <= Q1;
			op        <= OP_NONE;
			iw        <= 16'h0000;
			ret_addr  <= {PCW{1'b0}};
			squash    <= 1'b0;
			operand   <= 8'h00;
			result    <= 8'h00;
			last_op   <= OP_NONE;
			stk_push  <= 1'b0;
			stk_pop   <= 1'b0;
			pc_load   <= 1'b0;
			pc_target <= {PCW{1'b0}};
			refetch   <= 1'b0;
			mem_addr  <= 12'h000;
			mem_rd    <= 1'b0;
			mem_wdata <= 8'h00;
			mem_we    <= 1'b0;
		end else begin
			stk_push <= 1'b0;
			stk_pop  <= 1'b0;
			pc_load  <= 1'b0;
			mem_rd   <= 1'b0;
			mem_we   <= 1'b0;
			case (phase)
			Q1: begin
				phase    <= Q2;
				ret_addr <= pc_cur + `NSR_PC_STEP;
				iw       <= instr_word;
				// second call cycle
				// The word fetched behind a call is executed as idle
				if (squash || !instr_valid)
					op <= OP_IDLE;
				else
					op <= nsr_decode(instr_word);
				// idle decode
				// Idle words fall through every case below untouched
				if (!squash && instr_valid && nsr_decode(instr_word) == OP_NEG) begin
					mem_addr <= nsr_faddr(instr_word[8], instr_word[7:0], bank);
					mem_rd   <= 1'b1;
				end
			end
			Q2: begin
				phase <= Q3;
				if (op == OP_PUSH || op == OP_CALL)
					stk_push <= 1'b1;
			end
			Q3: begin
				phase <= Q4;
				if (op == OP_POP)
					stk_pop <= 1'b1;
				if (op == OP_NEG) begin
					operand   <= mem_rdata;
					result    <= neg_val;
					mem_wdata <= neg_val;
				end
			end
			Q4: begin
				phase   <= Q1;
				last_op <= op;
				if (op == OP_NEG)
					mem_we <= 1'b1;
				// target PC plus 2 plus 2n
				if (op == OP_CALL) begin
					pc_load   <= 1'b1;
					pc_target <= ret_addr + rel_off;
				end
				squash  <= (op == OP_CALL);
				refetch <= (op == OP_CALL);
			end
			default: phase <= Q1;
			endcase
		end
	end

	// ************************************************************
	// AXI4-Lite slave
	// ************************************************************
	reg        aw_held;
	reg        w_held;
	reg [5:0]  aw_addr;
	reg [31:0] w_data;
	reg [3:0]  w_strb;
	wire       wr_go;
	wire       rd_go;

	// Address and data are taken in either order, one write at a time
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go = aw_held && w_held;
	assign rd_go = s_axi_arvalid && s_axi_arready;

	// Write channel capture and response
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 6'h00;
			w_data       <= 32'h0000_0000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `NSR_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr == `NSR_OFF_BANK || aw_addr == `NSR_OFF_FLAGS) ?
					`NSR_RESP_OKAY : `NSR_RESP_SLVERR;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Bank select steers the negate address; flags are software visible
	always @(posedge aclk) begin
		if (!aresetn) begin
			bank  <= `NSR_RST_BANK;
			flags <= `NSR_RST_FLAGS;
		end else begin
			if (wr_go && aw_addr == `NSR_OFF_BANK && w_strb[0])
				bank <= w_data[3:0];
			// Execution wins over a software write in the same cycle
			if (phase == Q4 && op == OP_NEG) begin
				flags[`NSR_FLAG_N]  <= result[7];
				flags[`NSR_FLAG_Z]  <= (result == 8'h00);
				flags[`NSR_FLAG_OV] <= (operand == 8'h80);
				flags[`NSR_FLAG_C]  <= (operand == 8'h00);
				flags[`NSR_FLAG_DC] <= (operand[3:0] == 4'h0);
			end else if (wr_go && aw_addr == `NSR_OFF_FLAGS && w_strb[0])
				flags <= w_data[4:0];
		end
	end

	// Read channel: answer one cycle after the address is taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `NSR_RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `NSR_RESP_OKAY;
			case (s_axi_araddr)
			`NSR_OFF_BANK:  s_axi_rdata <= {28'h000_0000, bank};
			`NSR_OFF_FLAGS: s_axi_rdata <= {27'h000_0000, flags};
			`NSR_OFF_TOP:   s_axi_rdata <= {{(32-PCW){1'b0}}, stk_top};
			`NSR_OFF_LEVEL: s_axi_rdata <= {22'h00_0000, stk_empty, stk_full,
				{(8-SPW){1'b0}}, stk_level};
			`NSR_OFF_EXEC:  s_axi_rdata <= {16'h0000, 2'b00, last_op, result};
			default: begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= `NSR_RESP_SLVERR;
			end
			endcase
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule

// file: hdl/nsr_stack.v
// Hardware return stack with a registered top entry
module nsr_stack #(
	parameter W  = 21,
	parameter D  = 31,
	parameter PW = 5
) (
	// Clock and reset
	input  wire          aclk,
	input  wire          aresetn,
	// Commands, at most one per cycle
	input  wire          push,
	input  wire          pop,
	input  wire [W-1:0]  push_data,
	// State
	output reg  [W-1:0]  top,
	output reg  [PW-1:0] level,
	output wire          full,
	output wire          empty
);
	reg [W-1:0] mem [0:D-1];
	integer i;

	assign full  = (level == D[PW-1:0]);
	assign empty = (level == {PW{1'b0}});

	// Push beats pop unless the stack is full; overflowing pushes and underflowing pops are dropped
	always @(posedge aclk) begin
		if (!aresetn) begin
			level <= {PW{1'b0}};
			top   <= {W{1'b0}};
			for (i = 0; i < D; i = i + 1) begin
				mem[i] <= {W{1'b0}};
			end
		end else if (push && !full) begin
			mem[level] <= push_data;
			top        <= push_data;
			level      <= level + 1'b1;
		end else if (pop && !empty) begin
			// Entry pushed just before the discarded one becomes the top
			top   <= (level > 1) ? mem[level - 2'd2] : {W{1'b0}};
			level <= level - 1'b1;
		end
	end
endmodule

// file: tb/negate_stack_relcall_exec_bench.sv
// Testbench for the negate, stack and relative call block
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin fails++; \
	$display("unexpected %s expected %h seen %h", n, e, s); end end
module negate_stack_relcall_exec_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk, aresetn, awvalid_w, wvalid_w;
	logic [5:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb, phase;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, instr_valid, pc_load, refetch;
	logic [15:0] instr_word;
	logic [20:0] pc_cur, pc_target;
	logic [11:0] mem_addr;
	logic        mem_rd, mem_we;
	logic [7:0]  mem_rdata, mem_wdata, v, r;
	int          fails = 0;
	int          num_checks = 0;
	logic [15:0] nw [3] = '{16'h6D10, 16'h6C20, 16'h6C90};
	logic [11:0] na [3] = '{12'h310, 12'h020, 12'hF90};
	logic [7:0]  nv [3] = '{8'h3A, 8'h00, 8'h80};
	nsr_exec nsr_exec_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .instr_word,
		.instr_valid, .pc_cur, .pc_load, .pc_target, .refetch, .phase, .mem_addr,
		.mem_rd, .mem_rdata, .mem_wdata, .mem_we);
	nsr_mem_model nsr_mem_model_i (.aclk, .mem_addr, .mem_rd, .mem_we, .mem_wdata,
		.mem_rdata);
	// 250 MHz clock
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	// Launch one word so that the following edge is a decode edge
	task issue(input [15:0] w, input [20:0] p);
		do @(posedge aclk); while (phase !== 4'b1000);
		instr_word <= w;
		pc_cur <= p;
		instr_valid <= 1'b1;
		@(posedge aclk);
		instr_valid <= 1'b0;
	endtask
	// Register write; address and data released each on its own ready
	// Bready stays high afterwards so a following call never re-drives it in one step
	task wr(input [5:0] a, input [31:0] d, input [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		awvalid_w = 1'b1;
		wvalid_w = 1'b1;
		while (awvalid_w || wvalid_w) begin
			@(posedge aclk);
			if (awvalid_w && s_axi_awready === 1'b1) begin
				awvalid_w = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (wvalid_w && s_axi_wready === 1'b1) begin
				wvalid_w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		`CHK("bresp", er, s_axi_bresp)
	endtask
	// Register read, compared on the answering edge; rready stays high between calls
	task rd(input [5:0] a, input [31:0] e, input [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		`CHK($sformatf("rdata %h", a), e, s_axi_rdata)
		`CHK("rresp", er, s_axi_rresp)
	endtask
	task results;
		if (fails == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Watchdog, well beyond the roughly 110 cycles the tests need
	initial begin
		repeat (4000) @(posedge aclk);
		fails++;
		results();
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, instr_word, pc_cur} = '0;
		{instr_valid, aresetn} = '0;
		s_axi_wstrb = 4'hF;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(6'h04, 32'h0000_0000, 2'b00);
		rd(6'h0C, 32'h0000_0200, 2'b00);
		rd(6'h14, 32'h0000_0000, 2'b10);
		wr(6'h14, 32'h0000_0001, 2'b10);
		wr(6'h00, 32'h0000_0003, 2'b00);
		wr(6'h04, 32'h0000_001F, 2'b00);
		rd(6'h04, 32'h0000_001F, 2'b00);
		// Negate through both bank selections and both quick access halves
		for (int i = 0; i < 3; i++) begin
			v = nv[i];
			r = ~v + 8'h01;
			nsr_mem_model_i.m[na[i]] = v;
			issue(nw[i], 21'h00_0100);
			issue(16'h0000, 21'h00_0102);
			rd(6'h04, {27'h0, r[7], v == 8'h80, r == 8'h00, v[3:0] == 4'h0, v == 8'h00},
				2'b00);
			`CHK("negated byte", r, nsr_mem_model_i.m[na[i]])
		end
		// Two pushes then a pop leave the first push on top
		issue(16'h0005, 21'h00_0124);
		issue(16'h0005, 21'h00_0200);
		issue(16'h0006, 21'h00_0300);
		issue(16'h0000, 21'h00_0302);
		rd(6'h08, 32'h0000_0126, 2'b00);
		rd(6'h0C, 32'h0000_0001, 2'b00);
		// Backward call; the push in the flush cycle must be dropped
		issue(16'hDFFD, 21'h00_0300);
		issue(16'h0005, 21'h00_0400);
		issue(16'h0000, 21'h00_0402);
		`CHK("call target", 21'h00_02FC, pc_target)
		rd(6'h08, 32'h0000_0302, 2'b00);
		rd(6'h0C, 32'h0000_0002, 2'b00);
		// Furthest forward call, then an idle word with the top nibble set
		issue(16'hDBFF, 21'h00_1000);
		issue(16'h0000, 21'h00_1002);
		issue(16'hF123, 21'h00_1004);
		issue(16'h0000, 21'h00_1006);
		`CHK("call target", 21'h00_1800, pc_target)
		rd(6'h0C, 32'h0000_0003, 2'b00);
		rd(6'h10, 32'h0000_0280, 2'b00);
		results();
	end
endmodule

// file: tb/nsr_exec_checker.sv
// Assertion checker for the execute block
module nsr_exec_checker #(
	parameter PCW = 21
) (
	// Clock and reset
	input logic           aclk,
	input logic           aresetn,
	// Fetch unit
	input logic [15:0]    instr_word,
	input logic           instr_valid,
	input logic [PCW-1:0] pc_cur,
	input logic           pc_load,
	input logic [PCW-1:0] pc_target,
	input logic           refetch,
	input logic [3:0]     phase,
	// Data memory
	input logic [11:0]    mem_addr,
	input logic           mem_rd,
	input logic [7:0]     mem_rdata,
	input logic [7:0]     mem_wdata,
	input logic           mem_we
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Decoded at a decode edge; a word in the flush cycle is not taken
	wire take = phase == 4'b0001 && instr_valid && !refetch;
	wire neg  = take && instr_word[15:9] == 7'h36;
	wire call = take && instr_word[15:11] == 5'h1B;
	wire idle = take && (instr_word == 16'h0000 || instr_word[15:12] == 4'hF);
	a_neg_write: assert property (neg |-> ##4 mem_we)
		else $error("negate write-back missing");
	a_neg_cause: assert property (mem_we |-> $past(neg, 4))
		else $error("write-back without negate");
	a_neg_value: assert property (mem_we |-> mem_wdata == ~$past(mem_rdata, 2) + 8'h01)
		else $error("negate result wrong");
	a_quick_bank: assert property (neg && !instr_word[8] |=> mem_rd &&
		mem_addr == {{4{$past(instr_word[7])}}, $past(instr_word[7:0])})
		else $error("quick access address wrong");
	a_same_loc: assert property (mem_rd |=> $stable(mem_addr) [*3])
		else $error("address moved before write-back");
	a_call_target: assert property (call |-> ##4 pc_load && pc_target ==
		PCW'($past(pc_cur, 4) + 2 + {$past(instr_word[10:0], 4), 1'b0}
		- {$past(instr_word[10], 4), 12'h000}))
		else $error("call target wrong");
	a_load_cause: assert property (pc_load |-> $past(call, 4))
		else $error("program counter load without call");
	a_flush_span: assert property ($rose(pc_load) |-> refetch [*4] ##1 !refetch)
		else $error("flush cycle length wrong");
	a_idle_quiet: assert property (idle |=> !mem_rd ##3 !(mem_we || pc_load))
		else $error("idle word had an effect");
	// Sampled reset in the antecedent: the releasing edge itself is no ring step
	a_phase_ring: assert property (aresetn && phase == 4'b0001 |=> phase == 4'b0010
		##1 phase == 4'b0100 ##1 phase == 4'b1000 ##1 phase == 4'b0001)
		else $error("phase sequence wrong");
endmodule
bind nsr_exec nsr_exec_checker #(.PCW(PCW)) nsr_exec_checker_i (.aclk, .aresetn,
	.instr_word, .instr_valid, .pc_cur, .pc_load, .pc_target, .refetch, .phase,
	.mem_addr, .mem_rd, .mem_rdata, .mem_wdata, .mem_we);

// file: tb/nsr_mem_model.sv
// Banked data memory seen by the execute block
module nsr_mem_model (
	// Clock
	input logic        aclk,
	// Memory port
	input logic [11:0] mem_addr,
	input logic        mem_rd,
	input logic        mem_we,
	input logic [7:0]  mem_wdata,
	output logic [7:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] m [0:4095];
	logic [7:0] q = 8'h00;
	logic [1:0] hold = 2'h0;
	// Read data holds two cycles, then turns to its inverse so stale use shows
	always @(posedge aclk) begin
		hold <= mem_rd ? 2'h2 : (hold != 2'h0 ? hold - 2'h1 : 2'h0);
		if (mem_rd)
			q <= m[mem_addr];
		if (mem_we)
			m[mem_addr] <= mem_wdata;
	end
	assign mem_rdata = (hold != 2'h0) ? q : ~q;
endmodule
